// File: dpt_top.sv
`timescale 1ns/100ps
`default_nettype none
module dpt_top
  import dpt_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [DPT_AW-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic OSC_CLK_IN,
  output logic FIRST_PWM_PIN,
  output logic SECOND_PWM_PIN,
  output logic [1:0] PWM_OE,
  output logic [1:0] IRQ_REQUEST
);
  dpt_bus_t bus_state;
  logic [3:0] startstop;
  logic [3:0] bufmode;
  logic [1:0] outlevel;
  logic [2:0] clksel;
  logic [DPT_NFLAG-1:0] status0;
  logic [DPT_NFLAG-1:0] status1;
  logic [DPT_NFLAG-1:0] seen0;
  logic [DPT_NFLAG-1:0] seen1;
  logic [DPT_NFLAG-1:0] irqen0;
  logic [DPT_NFLAG-1:0] irqen1;
  logic [CW-1:0] count0;
  logic [CW-1:0] gra0, gra1, grb0, grb1, grc0, grc1, grd0, grd1;
  logic [4:0] prescale;
  logic osc_level;
  logic osc_prev;
  logic tick;
  logic acc;
  logic wr;
  logic rd;
  logic match_a, match_a1, match_b0, match_b1, match_c, match_d;
  logic ovf;
  logic [CW-1:0] next_count;
  logic [DPT_NFLAG-1:0] set0;
  logic [DPT_NFLAG-1:0] set1;

  // One wait state so every access is answered at the second edge
  assign acc = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = acc & (bus_state == DPT_BUS_IDLE);
  assign wr = AVS_WRITE & (bus_state == DPT_BUS_ACK);
  // Reads are latched in the wait cycle so the data stand at the accept edge
  assign rd = AVS_READ & (bus_state == DPT_BUS_IDLE);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bus_state <= DPT_BUS_IDLE;
    end else begin
      case (bus_state)
        DPT_BUS_IDLE: bus_state <= acc ? DPT_BUS_ACK : DPT_BUS_IDLE;
        DPT_BUS_ACK: bus_state <= DPT_BUS_IDLE;
        default: bus_state <= DPT_BUS_IDLE;
      endcase
    end
  end

  dpt_sync u_osc (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .d(OSC_CLK_IN),
    .q(osc_level)
  );

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      prescale <= '0;
      osc_prev <= 1'b0;
    end else begin
      prescale <= prescale + 5'h01;
      osc_prev <= osc_level;
    end
  end

  // Count-source select; the oscillator rises are sampled, so it must
  // run well below half of CLK
  always_comb begin
    case (clksel)
      DPT_CK_F1: tick = 1'b1;
      DPT_CK_F2: tick = &prescale[0:0];
      DPT_CK_F4: tick = &prescale[1:0];
      DPT_CK_F8: tick = &prescale[2:0];
      DPT_CK_F32: tick = &prescale[4:0];
      DPT_CK_OSC: tick = osc_level & ~osc_prev;
      default: tick = 1'b1;
    endcase
  end

  wire run = startstop[DPT_B_START0] & tick;
  assign match_a = run & (count0 == gra0);
  assign match_a1 = run & (count0 == gra1);
  assign match_b0 = run & (count0 == grb0);
  assign match_b1 = run & (count0 == grb1);
  assign match_c = run & bufmode[DPT_B_PERIOD_BUFFER_SELECT_BIT] == 1'b0 & (count0 == grc0);
  assign match_d = run & bufmode[DPT_B_SECOND_RETURN_BUFFER_SELECT_BIT] == 1'b0 & (count0 == grd0);
  assign ovf = run & (count0 == DPT_CNT_MAX) & ~match_a;

  // Channel 0 counts up only; channel 1 counter stays unused
  always_comb begin
    next_count = count0;
    if (match_a) begin
      next_count = '0;
    end else if (run) begin
      next_count = count0 + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      count0 <= '0;
    end else if (wr && AVS_ADDRESS == DPT_COUNT0) begin
      count0 <= AVS_WRITEDATA[CW-1:0];
    end else begin
      count0 <= next_count;
    end
  end

  // Start/stop: a zero to start is honoured only with stop-select set
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      startstop <= '0;
    end else if (wr && AVS_ADDRESS == DPT_STARTSTOP) begin
      startstop[DPT_B_SEL0] <= AVS_WRITEDATA[DPT_B_SEL0];
      startstop[DPT_B_SEL1] <= AVS_WRITEDATA[DPT_B_SEL1];
      if (AVS_WRITEDATA[DPT_B_START0] || startstop[DPT_B_SEL0]) begin
        startstop[DPT_B_START0] <= AVS_WRITEDATA[DPT_B_START0];
      end else if (match_a) begin
        startstop[DPT_B_START0] <= 1'b0;
      end
      if (AVS_WRITEDATA[DPT_B_START1] || startstop[DPT_B_SEL1]) begin
        startstop[DPT_B_START1] <= AVS_WRITEDATA[DPT_B_START1];
      end
    end else if (match_a && !startstop[DPT_B_SEL0]) begin
      startstop[DPT_B_START0] <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bufmode <= '0;
      outlevel <= '0;
      clksel <= DPT_CK_F1;
      irqen0 <= '0;
      irqen1 <= '0;
    end else if (wr) begin
      case (AVS_ADDRESS)
        DPT_BUFMODE: bufmode <= AVS_WRITEDATA[3:0];
        DPT_OUTLEVEL: outlevel <= AVS_WRITEDATA[1:0];
        DPT_CLKSEL: clksel <= AVS_WRITEDATA[2:0];
        DPT_IRQEN0: irqen0 <= AVS_WRITEDATA[DPT_NFLAG-1:0];
        default: ;
      endcase
    end
  end

  // Compare registers; buffers move in at each period match when enabled
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      gra0 <= DPT_GR_RESET;
      gra1 <= DPT_GR_RESET;
      grb0 <= DPT_GR_RESET;
      grb1 <= DPT_GR_RESET;
      grc0 <= DPT_GR_RESET;
      grc1 <= DPT_GR_RESET;
      grd0 <= DPT_GR_RESET;
      grd1 <= DPT_GR_RESET;
    end else begin
      if (match_a) begin
        if (bufmode[DPT_B_PERIOD_BUFFER_SELECT_BIT]) gra0 <= grc0;
        if (bufmode[DPT_B_FIRST_EDGE_BUFFER_SELECT_BIT]) gra1 <= grc1;
        if (bufmode[DPT_B_SECOND_RETURN_BUFFER_SELECT_BIT]) grb0 <= grd0;
        if (bufmode[DPT_B_SECOND_EDGE_BUFFER_SELECT_BIT]) grb1 <= grd1;
      end
      if (wr) begin
        case (AVS_ADDRESS)
          DPT_GRA0: gra0 <= AVS_WRITEDATA[CW-1:0];
          DPT_GRA1: gra1 <= AVS_WRITEDATA[CW-1:0];
          DPT_GRB0: grb0 <= AVS_WRITEDATA[CW-1:0];
          DPT_GRB1: grb1 <= AVS_WRITEDATA[CW-1:0];
          DPT_GRC0: grc0 <= AVS_WRITEDATA[CW-1:0];
          DPT_GRC1: grc1 <= AVS_WRITEDATA[CW-1:0];
          DPT_GRD0: grd0 <= AVS_WRITEDATA[CW-1:0];
          DPT_GRD1: grd1 <= AVS_WRITEDATA[CW-1:0];
          default: ;
        endcase
      end
    end
  end

  // Waveforms: a write of the level register forces initial levels
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      FIRST_PWM_PIN <= 1'b0;
      SECOND_PWM_PIN <= 1'b0;
    end else if (wr && AVS_ADDRESS == DPT_OUTLEVEL) begin
      FIRST_PWM_PIN <= AVS_WRITEDATA[0];
      SECOND_PWM_PIN <= AVS_WRITEDATA[1];
    end else begin
      if (match_a) begin
        FIRST_PWM_PIN <= outlevel[0];
      end else if (match_a1) begin
        FIRST_PWM_PIN <= ~outlevel[0];
      end
      if (match_b0 || match_a) begin
        SECOND_PWM_PIN <= outlevel[1];
      end else if (match_b1) begin
        SECOND_PWM_PIN <= ~outlevel[1];
      end
    end
  end

  // Only channel 0 pins drive; the other six are left to port logic
  assign PWM_OE = 2'b11;

  // Flags: set beats clear; a zero clears only a bit that was read as one
  assign set0 = {1'b0, ovf, match_d, match_c, match_b0, match_a};
  assign set1 = {2'b00, match_b1, match_a1, 2'b00};

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      status0 <= '0;
      seen0 <= '0;
      status1 <= '0;
      seen1 <= '0;
    end else begin
      if (rd && AVS_ADDRESS == DPT_STATUS0) seen0 <= status0;
      if (rd && AVS_ADDRESS == DPT_STATUS1) seen1 <= status1;
      if (wr && AVS_ADDRESS == DPT_STATUS0) begin
        status0 <= (status0 & ~(seen0 & ~AVS_WRITEDATA[DPT_NFLAG-1:0]))
                   | set0;
        seen0 <= '0;
      end else begin
        status0 <= status0 | set0;
      end
      if (wr && AVS_ADDRESS == DPT_STATUS1) begin
        status1 <= (status1 & ~(seen1 & ~AVS_WRITEDATA[DPT_NFLAG-1:0]))
                   | set1;
        seen1 <= '0;
      end else begin
        status1 <= status1 | set1;
      end
    end
  end

  // Level requests per channel: no acknowledge path touches the flags
  assign IRQ_REQUEST[0] = |(status0 & irqen0);
  assign IRQ_REQUEST[1] = |(status1 & irqen1);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      AVS_READDATA <= '0;
    end else if (rd) begin
      case (AVS_ADDRESS)
        DPT_STARTSTOP: AVS_READDATA <= {28'h0000000, startstop};
        DPT_BUFMODE: AVS_READDATA <= {28'h0000000, bufmode};
        DPT_OUTLEVEL: AVS_READDATA <= {30'h0, outlevel};
        DPT_CLKSEL: AVS_READDATA <= {29'h0, clksel};
        DPT_STATUS0: AVS_READDATA <= {26'h0, status0};
        DPT_STATUS1: AVS_READDATA <= {26'h0, status1};
        DPT_IRQEN0: AVS_READDATA <= {26'h0, irqen0};
        DPT_COUNT0: AVS_READDATA <= {16'h0000, count0};
        DPT_GRA0: AVS_READDATA <= {16'h0000, gra0};
        DPT_GRA1: AVS_READDATA <= {16'h0000, gra1};
        DPT_GRB0: AVS_READDATA <= {16'h0000, grb0};
        DPT_GRB1: AVS_READDATA <= {16'h0000, grb1};
        DPT_GRC0: AVS_READDATA <= {16'h0000, grc0};
        DPT_GRC1: AVS_READDATA <= {16'h0000, grc1};
        DPT_GRD0: AVS_READDATA <= {16'h0000, grd0};
        DPT_GRD1: AVS_READDATA <= {16'h0000, grd1};
        default: AVS_READDATA <= '0;
      endcase
    end
  end

  period_restart_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    match_a |=> count0 == '0 || $past(wr))
    else $error("counter not cleared at period match");
  auto_stop_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    match_a && !startstop[DPT_B_SEL0] && !wr |=> !startstop[DPT_B_START0])
    else $error("start bit kept after period match");
  irq_level_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    match_a && irqen0[DPT_F_A] && !wr |=> IRQ_REQUEST[0])
    else $error("request missing for enabled flag");
  flag_set_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    match_a |=> status0[DPT_F_A])
    else $error("period match flag lost");
  flag_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    status0[DPT_F_A] && !(wr && AVS_ADDRESS == DPT_STATUS0)
    |=> status0[DPT_F_A])
    else $error("flag cleared without write");
  stop_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !startstop[DPT_B_START0] && !wr |=> $stable(FIRST_PWM_PIN))
    else $error("pin moved while stopped");
  count_up_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    run && !match_a && !wr |=> count0 == $past(count0) + 16'h0001)
    else $error("counter did not increment");
  level_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    wr && AVS_ADDRESS == DPT_OUTLEVEL
    |=> FIRST_PWM_PIN == $past(AVS_WRITEDATA[0]))
    else $error("initial level not driven");
endmodule : dpt_top
`default_nettype wire

// File: dpt_pkg.sv
// What this block does
// - Dual-output PWM mode makes two waveforms sharing one period.
// - Count source is clock divided by 1, 2, 4, 8, 32 or fast oscillator.
// - Only channel 0 counts upward; software reads and writes its count.
// - PWM period is period compare plus one count periods.
// - First output active for period minus first activation count periods.
// - Second output active for return minus activation count periods.
// - Writing one to channel 0 start bit starts counting.
// - With stop-select one, writing zero stops; pins hold their level.
// - With stop-select zero, period match stops and clears the start bit.
// - Compare matches and channel 0 overflow raise interrupt flags.
// - Only the two channel 0 pins output PWM; six others are I/O.
// - Writing output-level control drives initial levels onto output pins.
// - Flags clear only by writing zero after reading one.
// - A0 period, A1 first activation, B0 second return, B1 second activation.
// - With buffer bits set, C and D registers hold next compare values.
// - Channel 0 merges five sources into one request; channel 1 enables cannot be written, so its request stays zero.
// - Request is one while any enabled flag is one.
// - Request drops once no enabled flag remains, without acknowledge.
// - Acknowledge leaves flags; software reads status and clears them.
// - Pin select, filter, I/O control and polarity registers are ignored.
package dpt_pkg;
  localparam int DPT_AW = 6;
  localparam logic [DPT_AW-1:0] DPT_STARTSTOP = 6'h00;
  localparam logic [DPT_AW-1:0] DPT_BUFMODE = 6'h04;
  localparam logic [DPT_AW-1:0] DPT_OUTLEVEL = 6'h08;
  localparam logic [DPT_AW-1:0] DPT_CLKSEL = 6'h0C;
  localparam logic [DPT_AW-1:0] DPT_STATUS0 = 6'h10;
  localparam logic [DPT_AW-1:0] DPT_IRQEN0 = 6'h14;
  localparam logic [DPT_AW-1:0] DPT_COUNT0 = 6'h18;
  localparam logic [DPT_AW-1:0] DPT_GRA0 = 6'h1C;
  localparam logic [DPT_AW-1:0] DPT_GRA1 = 6'h20;
  localparam logic [DPT_AW-1:0] DPT_GRB0 = 6'h24;
  localparam logic [DPT_AW-1:0] DPT_GRB1 = 6'h28;
  localparam logic [DPT_AW-1:0] DPT_GRC0 = 6'h2C;
  localparam logic [DPT_AW-1:0] DPT_GRC1 = 6'h30;
  localparam logic [DPT_AW-1:0] DPT_GRD0 = 6'h34;
  localparam logic [DPT_AW-1:0] DPT_GRD1 = 6'h38;
  localparam logic [DPT_AW-1:0] DPT_STATUS1 = 6'h3C;
  // Start/stop field positions
  localparam int DPT_B_START0 = 0;
  localparam int DPT_B_START1 = 1;
  localparam int DPT_B_SEL0 = 2;
  localparam int DPT_B_SEL1 = 3;
  // Buffer select positions (period, first, return, second)
  localparam int DPT_B_PERIOD_BUFFER_SELECT_BIT = 0;
  localparam int DPT_B_FIRST_EDGE_BUFFER_SELECT_BIT = 1;
  localparam int DPT_B_SECOND_RETURN_BUFFER_SELECT_BIT = 2;
  localparam int DPT_B_SECOND_EDGE_BUFFER_SELECT_BIT = 3;
  // Status flag positions: A,B,C,D matches, overflow
  localparam int DPT_F_A = 0;
  localparam int DPT_F_B = 1;
  localparam int DPT_F_C = 2;
  localparam int DPT_F_D = 3;
  localparam int DPT_F_OVF = 4;
  localparam int DPT_NFLAG = 6;
  localparam logic [15:0] DPT_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] DPT_GR_RESET = 16'hFFFF;
  localparam logic [2:0] DPT_CK_F1 = 3'h0;
  localparam logic [2:0] DPT_CK_F2 = 3'h1;
  localparam logic [2:0] DPT_CK_F4 = 3'h2;
  localparam logic [2:0] DPT_CK_F8 = 3'h3;
  localparam logic [2:0] DPT_CK_F32 = 3'h4;
  localparam logic [2:0] DPT_CK_OSC = 3'h5;
  localparam int DPT_SYNC_STAGES = 3;
  typedef enum logic [1:0] {
    DPT_BUS_IDLE = 2'b00,
    DPT_BUS_ACK = 2'b01
  } dpt_bus_t;
endpackage : dpt_pkg

// File: dpt_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Three-stage capture; a change counts once stages two and three agree.
module dpt_sync
  import dpt_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic d,
  output var logic q
);
  logic [DPT_SYNC_STAGES-1:0] stage;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      stage <= '0;
    end else begin
      stage <= {stage[DPT_SYNC_STAGES-2:0], d};
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      q <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      q <= stage[2];
    end
  end
endmodule : dpt_sync
`default_nettype wire

// File: dpt_load_model.sv
`timescale 1ns/100ps
`default_nettype none
// Load on both pins: measures period of the first pin and high widths
module dpt_load_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin_a,
  input wire logic pin_b,
  output logic [31:0] period_a,
  output logic [31:0] high_a,
  output logic [31:0] high_b
);
  logic last_a, last_b;
  logic [31:0] run_a, cnt_a, cnt_b;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_a <= 1'b0;
      last_b <= 1'b0;
      run_a <= '0;
      cnt_a <= '0;
      cnt_b <= '0;
      period_a <= '0;
      high_a <= '0;
      high_b <= '0;
    end else begin
      last_a <= pin_a;
      last_b <= pin_b;
      // Rising edge to rising edge gives one full period
      if (pin_a && !last_a) begin
        period_a <= run_a;
        run_a <= 32'h1;
      end else run_a <= run_a + 32'h1;
      if (pin_a) cnt_a <= cnt_a + 32'h1;
      else if (last_a) begin
        high_a <= cnt_a;
        cnt_a <= '0;
      end
      if (pin_b) cnt_b <= cnt_b + 32'h1;
      else if (last_b) begin
        high_b <= cnt_b;
        cnt_b <= '0;
      end
    end
  end
endmodule : dpt_load_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dpt_pkg::*;
  typedef struct {logic [2:0] ck; int m, n, p, q, per, w1, w2;} dpt_row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [1:0] osc = '0;
  logic [5:0] adr = '0;
  logic [31:0] wd = '0;
  logic [31:0] rdata, q;
  logic pa, pb, wq;
  logic [1:0] oe, irq, lvl;
  logic [31:0] per, hia, hib;
  int num_errors = 0;
  int n_compared = 0;
  // Oscillator is the top bit of a 2-bit count: a divide by 4
  dpt_row_t rows [6] = '{
    '{DPT_CK_F1, 19, 5, 15, 10, 20, 14, 5},
    '{DPT_CK_F2, 9, 2, 8, 3, 20, 14, 10},
    '{DPT_CK_F4, 7, 0, 7, 0, 32, 28, 28},
    '{DPT_CK_F8, 4, 1, 3, 2, 40, 24, 8},
    '{DPT_CK_F32, 3, 1, 2, 1, 128, 64, 32},
    '{DPT_CK_OSC, 5, 3, 4, 1, 24, 8, 12}};

  always #5 clk = ~clk;
  always @(posedge clk) osc <= osc + 2'h1;

  dpt_top DUT (.CLK(clk), .SYS_RST(sys_rst), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq),
    .OSC_CLK_IN(osc[1]), .FIRST_PWM_PIN(pa), .SECOND_PWM_PIN(pb),
    .PWM_OE(oe), .IRQ_REQUEST(irq));

  dpt_load_model load (.clk(clk), .sys_rst(sys_rst), .pin_a(pa),
    .pin_b(pb), .period_a(per), .high_a(hia), .high_b(hib));

  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 100);
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 100) begin
      num_errors++;
      $display("wrong value at %0t: bus hang", $time);
    end
    q = rdata;
  endtask : bus

  task automatic wrr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wrr

  task automatic rdm(input logic [5:0] a, input logic [31:0] mask,
                     input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q & mask, exp, "register read");
  endtask : rdm

  task automatic load_cmp(input int m, input int n, input int p,
                          input int q0);
    wrr(DPT_GRA0, 32'(m));
    wrr(DPT_GRA1, 32'(n));
    wrr(DPT_GRB0, 32'(p));
    wrr(DPT_GRB1, 32'(q0));
    wrr(DPT_COUNT0, 32'h0);
  endtask : load_cmp

  task automatic check_wave(input dpt_row_t r);
    chk(per, 32'(r.per), "period");
    chk(hia, 32'(r.w1), "first width");
    chk(hib, 32'(r.w2), "second width");
  endtask : check_wave

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rdm(DPT_GRA0, 32'hFFFFFFFF, 32'h0000FFFF);
    rdm(DPT_STARTSTOP, 32'hFFFFFFFF, 32'h0);
    chk({30'h0, irq}, 32'h0, "irq after reset");
    chk({30'h0, oe}, 32'h3, "output enables");
    wrr(DPT_COUNT0, 32'h0123);
    rdm(DPT_COUNT0, 32'hFFFF, 32'h0123);
    $display("test reset done");
    foreach (rows[i]) begin
      wrr(DPT_CLKSEL, {29'h0, rows[i].ck});
      load_cmp(rows[i].m, rows[i].n, rows[i].p, rows[i].q);
      wrr(DPT_STARTSTOP, 32'h5);
      repeat (5 * rows[i].per) @(posedge clk);
      check_wave(rows[i]);
      wrr(DPT_STARTSTOP, 32'h4);
      // The last counting edge is the accept edge itself
      @(posedge clk);
      lvl = {pa, pb};
      repeat (20) @(posedge clk);
      chk({30'h0, pa, pb}, {30'h0, lvl}, "held level");
      $display("test row %0d done", i);
    end
    // Auto stop at period match, then flag handshake on the A match flag
    wrr(DPT_CLKSEL, {29'h0, DPT_CK_F1});
    load_cmp(9, 2, 8, 3);
    wrr(DPT_COUNT0, 32'hFFFD);
    wrr(DPT_STARTSTOP, 32'h1);
    repeat (40) @(posedge clk);
    rdm(DPT_STARTSTOP, 32'h1, 32'h0);
    wrr(DPT_STATUS0, 32'h0);
    rdm(DPT_STATUS0, 32'h1, 32'h1);
    chk({31'h0, irq[0]}, 32'h0, "irq masked");
    wrr(DPT_STATUS0, 32'h1F);
    rdm(DPT_STATUS0, 32'h1, 32'h1);
    wrr(DPT_IRQEN0, 32'h1);
    @(posedge clk);
    chk({31'h0, irq[0]}, 32'h1, "irq raised");
    wrr(DPT_STATUS0, 32'h1E);
    rdm(DPT_STATUS0, 32'h1, 32'h0);
    chk({30'h0, irq}, 32'h0, "irq dropped");
    rdm(DPT_STATUS0, 32'h10, 32'h10);
    rdm(DPT_STATUS1, 32'hC, 32'hC);
    $display("test flags done");
    // Buffers loaded with select bits clear, then armed
    wrr(DPT_BUFMODE, 32'h0);
    load_cmp(9, 2, 8, 3);
    wrr(DPT_GRC0, 32'd19);
    wrr(DPT_GRC1, 32'd5);
    wrr(DPT_GRD0, 32'd15);
    wrr(DPT_GRD1, 32'd10);
    wrr(DPT_BUFMODE, 32'hF);
    wrr(DPT_STARTSTOP, 32'h5);
    repeat (120) @(posedge clk);
    check_wave('{DPT_CK_F1, 19, 5, 15, 10, 20, 14, 5});
    wrr(DPT_STARTSTOP, 32'h4);
    $display("test buffers done");
    wrr(DPT_OUTLEVEL, 32'h3);
    @(posedge clk);
    chk({30'h0, pa, pb}, 32'h3, "initial level high");
    wrr(DPT_OUTLEVEL, 32'h0);
    @(posedge clk);
    chk({30'h0, pa, pb}, 32'h0, "initial level low");
    $display("test output level done");
    // Reset while counting must leave the block stopped and quiet
    wrr(DPT_STARTSTOP, 32'h5);
    repeat (10) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rdm(DPT_STARTSTOP, 32'hFFFFFFFF, 32'h0);
    chk({30'h0, pa, pb}, 32'h0, "pins after reset");
    chk({30'h0, irq}, 32'h0, "irq after mid reset");
    $display("test mid reset done");
    print_verdict();
  end

  // Tests need about 1900 cycles; about sixteen times that means a hang
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule : tb
`default_nettype wire
